// *** inc/dxo_pkg.sv ***
// Package: opcode encodings, timing table and carrier structs for the transfer decoder
package dxo_pkg;

	// ==========================================================
	// Opcode encodings of the data transfer group
	localparam logic [7:0] OP_A_FROM_RN = 8'hE8; // low 3 bits pick bank register
	localparam logic [7:0] OP_A_FROM_DIR = 8'hE5;
	localparam logic [7:0] OP_A_FROM_IND = 8'hE6; // low bit picks pointer register
	localparam logic [7:0] OP_A_FROM_IMM = 8'h74;
	localparam logic [7:0] OP_RN_FROM_A = 8'hF8;
	localparam logic [7:0] OP_RN_FROM_DIR = 8'hA8;
	localparam logic [7:0] OP_RN_FROM_IMM = 8'h78;
	localparam logic [7:0] OP_DIR_FROM_A = 8'hF5;
	localparam logic [7:0] OP_DIR_FROM_RN = 8'h88;
	localparam logic [7:0] OP_DIR_FROM_DIR = 8'h85;
	localparam logic [7:0] OP_DIR_FROM_IND = 8'h86;
	localparam logic [7:0] OP_DIR_FROM_IMM = 8'h75;
	localparam logic [7:0] OP_IND_FROM_A = 8'hF6;
	localparam logic [7:0] OP_IND_FROM_DIR = 8'hA6;
	localparam logic [7:0] OP_IND_FROM_IMM = 8'h76;
	localparam logic [7:0] OP_DP_LOAD = 8'h90;
	localparam logic [7:0] OP_CODE_DP = 8'h93;
	localparam logic [7:0] OP_CODE_PC = 8'h83;
	localparam logic [7:0] OP_XRD_IND = 8'hE2;
	localparam logic [7:0] OP_XRD_DP = 8'hE0;
	localparam logic [7:0] OP_XWR_IND = 8'hF2;
	localparam logic [7:0] OP_XWR_DP = 8'hF0;
	localparam logic [7:0] OP_PUSH = 8'hC0;
	localparam logic [7:0] OP_POP = 8'hD0;
	localparam logic [7:0] OP_SWAP_RN = 8'hC8;
	localparam logic [7:0] OP_SWAP_DIR = 8'hC5;
	localparam logic [7:0] OP_SWAP_IND = 8'hC6;
	localparam logic [7:0] OP_NIB_SWAP = 8'hD6;
	localparam logic [7:0] MASK_RN = 8'hF8; // compare mask for bank register forms
	localparam logic [7:0] MASK_IND = 8'hFE; // compare mask for pointer register forms

	// ==========================================================
	// Field layout and reset values
	localparam logic [7:0] SFR_BASE = 8'h80; // direct addresses at and above are SFRs
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] BIT_RAM_BASE = 8'h20; // 128 addressable bits live in 16 bytes
	localparam logic [7:0] BIT_SFR_STEP = 8'h08; // bit-addressable SFRs sit on 8-byte rows
	localparam logic [7:0] LOW_NIBBLE = 8'h0F;

	// ==========================================================
	// Lengths and cycle counts
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	localparam logic [2:0] CYC_3 = 3'h3;
	localparam logic [2:0] CYC_4 = 3'h4;
	localparam logic [2:0] CYC_5 = 3'h5;

	// ==========================================================
	// Operation classes
	typedef enum logic [4:0] {
		K_NONE = 5'h00, K_A_RN = 5'h01, K_A_DIR = 5'h02, K_A_IND = 5'h03,
		K_A_IMM = 5'h04, K_RN_A = 5'h05, K_RN_DIR = 5'h06, K_RN_IMM = 5'h07,
		K_DIR_A = 5'h08, K_DIR_RN = 5'h09, K_DIR_DIR = 5'h0A, K_DIR_IND = 5'h0B,
		K_DIR_IMM = 5'h0C, K_IND_A = 5'h0D, K_IND_DIR = 5'h0E, K_IND_IMM = 5'h0F,
		K_DP_LOAD = 5'h10, K_CODE_DP = 5'h11, K_CODE_PC = 5'h12, K_XRD_IND = 5'h13,
		K_XRD_DP = 5'h14, K_XWR_IND = 5'h15, K_XWR_DP = 5'h16, K_PUSH = 5'h17,
		K_POP = 5'h18, K_SWAP_RN = 5'h19, K_SWAP_DIR = 5'h1A, K_SWAP_IND = 5'h1B,
		K_NIB_SWAP = 5'h1C
	} dxo_kind_t;

	// Decoder answer for one opcode byte
	typedef struct packed {
		dxo_kind_t kind;
		logic [1:0] len;
		logic [2:0] cycles;
		logic [2:0] reg_sel;
		logic known;
	} dxo_dec_t;

	// Memory request carrier (external data, code memory)
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} dxo_mreq_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'h0, S_FETCH = 2'h1, S_EXEC = 2'h2, S_DONE = 2'h3
	} dxo_state_t;

endpackage

// *** design/dxo_decode.sv ***
// Opcode decoder: class, byte length and cycle count of each transfer form
`timescale 1ns/10ps
module dxo_decode (
	// Opcode in
	input wire logic [7:0] opcode,
	// Decoded form
	output dxo_pkg::dxo_dec_t dec
);
	// Pure table lookup; unknown opcodes answer known=0
	always_comb begin
		dec = '0;
		dec.kind = dxo_pkg::K_NONE;
		dec.reg_sel = opcode[2:0];
		dec.known = 1'b1;
		if ((opcode & dxo_pkg::MASK_RN) == dxo_pkg::OP_A_FROM_RN) begin
			dec.kind = dxo_pkg::K_A_RN; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_1;
		end else if ((opcode & dxo_pkg::MASK_RN) == dxo_pkg::OP_RN_FROM_A) begin
			dec.kind = dxo_pkg::K_RN_A; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_1;
		end else if ((opcode & dxo_pkg::MASK_RN) == dxo_pkg::OP_RN_FROM_DIR) begin
			dec.kind = dxo_pkg::K_RN_DIR; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_3;
		end else if ((opcode & dxo_pkg::MASK_RN) == dxo_pkg::OP_RN_FROM_IMM) begin
			dec.kind = dxo_pkg::K_RN_IMM; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_2;
		end else if ((opcode & dxo_pkg::MASK_RN) == dxo_pkg::OP_DIR_FROM_RN) begin
			dec.kind = dxo_pkg::K_DIR_RN; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_2;
		end else if ((opcode & dxo_pkg::MASK_RN) == dxo_pkg::OP_SWAP_RN) begin
			dec.kind = dxo_pkg::K_SWAP_RN; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_2;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_A_FROM_IND) begin
			dec.kind = dxo_pkg::K_A_IND; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_2;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_DIR_FROM_IND) begin
			dec.kind = dxo_pkg::K_DIR_IND; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_3;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_IND_FROM_A) begin
			dec.kind = dxo_pkg::K_IND_A; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_2;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_IND_FROM_DIR) begin
			dec.kind = dxo_pkg::K_IND_DIR; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_3;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_IND_FROM_IMM) begin
			dec.kind = dxo_pkg::K_IND_IMM; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_2;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_XRD_IND) begin
			dec.kind = dxo_pkg::K_XRD_IND; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_4;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_XWR_IND) begin
			dec.kind = dxo_pkg::K_XWR_IND; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_5;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_SWAP_IND) begin
			dec.kind = dxo_pkg::K_SWAP_IND; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_3;
		end else if ((opcode & dxo_pkg::MASK_IND) == dxo_pkg::OP_NIB_SWAP) begin
			dec.kind = dxo_pkg::K_NIB_SWAP; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_3;
		end else begin
			unique case (opcode)
				dxo_pkg::OP_A_FROM_DIR: begin
					dec.kind = dxo_pkg::K_A_DIR; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_2;
				end
				dxo_pkg::OP_A_FROM_IMM: begin
					dec.kind = dxo_pkg::K_A_IMM; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_2;
				end
				dxo_pkg::OP_DIR_FROM_A: begin
					dec.kind = dxo_pkg::K_DIR_A; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_2;
				end
				dxo_pkg::OP_DIR_FROM_DIR: begin
					dec.kind = dxo_pkg::K_DIR_DIR; dec.len = dxo_pkg::LEN_3; dec.cycles = dxo_pkg::CYC_3;
				end
				dxo_pkg::OP_DIR_FROM_IMM: begin
					dec.kind = dxo_pkg::K_DIR_IMM; dec.len = dxo_pkg::LEN_3; dec.cycles = dxo_pkg::CYC_3;
				end
				dxo_pkg::OP_DP_LOAD: begin
					dec.kind = dxo_pkg::K_DP_LOAD; dec.len = dxo_pkg::LEN_3; dec.cycles = dxo_pkg::CYC_3;
				end
				dxo_pkg::OP_CODE_DP: begin
					dec.kind = dxo_pkg::K_CODE_DP; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_5;
				end
				dxo_pkg::OP_CODE_PC: begin
					dec.kind = dxo_pkg::K_CODE_PC; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_4;
				end
				dxo_pkg::OP_XRD_DP: begin
					dec.kind = dxo_pkg::K_XRD_DP; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_3;
				end
				dxo_pkg::OP_XWR_DP: begin
					dec.kind = dxo_pkg::K_XWR_DP; dec.len = dxo_pkg::LEN_1; dec.cycles = dxo_pkg::CYC_4;
				end
				dxo_pkg::OP_PUSH: begin
					dec.kind = dxo_pkg::K_PUSH; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_3;
				end
				dxo_pkg::OP_POP: begin
					dec.kind = dxo_pkg::K_POP; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_2;
				end
				dxo_pkg::OP_SWAP_DIR: begin
					dec.kind = dxo_pkg::K_SWAP_DIR; dec.len = dxo_pkg::LEN_2; dec.cycles = dxo_pkg::CYC_3;
				end
				default: dec.known = 1'b0;
			endcase
		end
	end
endmodule

// *** design/dxo_core.sv ***
// Data transfer executor: takes an opcode with operands, runs it over internal/external/code memory
// ==========================================================
// How it works
// - Internal transfers move between any RAM or special registers, four addressing forms.
// - External data moves only to or from accumulator, indirectly addressed.
// - Code memory is only read, at accumulator plus pointer or counter.
// - Bank register to or from accumulator: 1 byte, 1 cycle.
// - Accumulator loads from direct, indirect or immediate take 2 cycles; direct 2 bytes, indirect 1, immediate 2.
// - Bank register from direct 2 bytes 3 cycles; from immediate 2 and 2.
// - Direct from accumulator or bank register 2/2; from indirect 2/3.
// - Direct-to-direct and immediate-to-direct: 3 bytes, 3 cycles.
// - Indirect writes: accumulator 1/2, direct 2/3, immediate 2/2.
// - Data pointer load of 16-bit constant: 3 bytes, 3 cycles.
// - Code read 1 byte; pointer-based 5 cycles, counter-based 4 cycles.
// - External reads 1 byte; 8-bit address 4 cycles, 16-bit 3 cycles.
// - External writes 1 byte; 8-bit address 5 cycles, 16-bit 4 cycles.
// - Push 2 bytes 3 cycles; pop 2 bytes 2 cycles.
// - Swaps: bank register 1/2, direct 2/3, indirect 1/3.
// - Nibble swap with indirect RAM: 1 byte, 3 cycles.
`timescale 1ns/10ps
module dxo_core #(
	parameter int RAM_WORDS = 256
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Instruction in: opcode and up to two operand bytes, program counter of the next byte
	input wire logic instr_valid,
	input wire logic [7:0] instr_op,
	input wire logic [7:0] instr_b1,
	input wire logic [7:0] instr_b2,
	input wire logic [15:0] instr_pc,
	// Memory answers (same clock, combinational while the request stands, captured on the edge that ends it)
	input wire logic [7:0] xdata_rdata,
	input wire logic [7:0] code_rdata,
	input wire logic [7:0] ind_page,
	// Status and memory requests
	output logic instr_ready,
	output logic instr_done,
	output logic [1:0] instr_len,
	output logic instr_illegal,
	output dxo_pkg::dxo_mreq_t xdata_req,
	output dxo_pkg::dxo_mreq_t code_req,
	output logic [7:0] acc_out,
	output logic [15:0] dp_out,
	output logic [7:0] sp_out
);
	// ==========================================================
	// State
	typedef struct packed {
		dxo_pkg::dxo_state_t st;
		dxo_pkg::dxo_kind_t kind;
		logic [2:0] left;
		logic [2:0] rsel;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [15:0] pc;
		logic [7:0] acc;
		logic [15:0] dp;
		logic [7:0] sp;
		logic [7:0] psw_bank; // bank select, bits 4:3 used
		logic ready;
		logic done;
		logic [1:0] len;
		logic illegal;
		dxo_pkg::dxo_mreq_t xreq;
		dxo_pkg::dxo_mreq_t creq;
	} dxo_core_st_t;

	dxo_core_st_t s_r, s_nxt;
	dxo_pkg::dxo_dec_t dec;
	logic [7:0] ram [RAM_WORDS]; // internal RAM incl. bank registers and bit area
	logic ram_we;
	logic [7:0] ram_wa, ram_wd;

	dxo_decode u_dec (
		.opcode(instr_op),
		.dec(dec)
	);

	// Address helpers: bank register and pointer register locations
	function automatic logic [7:0] bank_addr(input logic [7:0] psw, input logic [2:0] r);
		bank_addr = {3'h0, psw[4:3], r};
	endfunction

	function automatic logic [7:0] rd8(input logic [7:0] a);
		rd8 = ram[a];
	endfunction

	// ==========================================================
	// Next state and internal RAM write port; all RAM effects land on the last cycle
	always_comb begin
		logic [7:0] ptr, tmp, addr_rn;
		ptr = 8'h00;
		tmp = 8'h00;
		addr_rn = 8'h00;
		s_nxt = s_r;
		ram_we = 1'b0;
		ram_wa = 8'h00;
		ram_wd = 8'h00;
		s_nxt.done = 1'b0;
		s_nxt.xreq.rd = 1'b0;
		s_nxt.xreq.wr = 1'b0;
		s_nxt.creq.rd = 1'b0;
		addr_rn = bank_addr(s_r.psw_bank, s_r.rsel);
		ptr = rd8(bank_addr(s_r.psw_bank, {2'h0, s_r.rsel[0]}));
		unique case (s_r.st)
			dxo_pkg::S_IDLE: begin
				s_nxt.ready = 1'b1;
				if (instr_valid) begin
					s_nxt.ready = 1'b0;
					s_nxt.illegal = ~dec.known;
					s_nxt.kind = dec.kind;
					s_nxt.left = dec.cycles;
					s_nxt.len = dec.len;
					s_nxt.rsel = dec.reg_sel;
					s_nxt.b1 = instr_b1;
					s_nxt.b2 = instr_b2;
					s_nxt.pc = instr_pc;
					s_nxt.st = dec.known ? dxo_pkg::S_EXEC : dxo_pkg::S_DONE;
				end
			end
			dxo_pkg::S_EXEC: begin
				// Count down the documented cycles; work lands on the final one
				s_nxt.left = s_r.left - 3'h1;
				// External and code requests issue early so the answer is back by the final cycle
				if (s_r.left == dxo_pkg::CYC_2) begin
					unique case (s_r.kind)
						dxo_pkg::K_XRD_IND, dxo_pkg::K_XWR_IND: begin
							s_nxt.xreq.addr = {ind_page, ptr};
							s_nxt.xreq.rd = (s_r.kind == dxo_pkg::K_XRD_IND);
							s_nxt.xreq.wr = (s_r.kind == dxo_pkg::K_XWR_IND);
							s_nxt.xreq.wdata = s_r.acc;
						end
						dxo_pkg::K_XRD_DP, dxo_pkg::K_XWR_DP: begin
							s_nxt.xreq.addr = s_r.dp;
							s_nxt.xreq.rd = (s_r.kind == dxo_pkg::K_XRD_DP);
							s_nxt.xreq.wr = (s_r.kind == dxo_pkg::K_XWR_DP);
							s_nxt.xreq.wdata = s_r.acc;
						end
						dxo_pkg::K_CODE_DP: begin
							s_nxt.creq.addr = s_r.dp + {8'h00, s_r.acc};
							s_nxt.creq.rd = 1'b1;
						end
						dxo_pkg::K_CODE_PC: begin
							s_nxt.creq.addr = s_r.pc + {8'h00, s_r.acc};
							s_nxt.creq.rd = 1'b1;
						end
						default: ;
					endcase
				end
				if (s_r.left == dxo_pkg::CYC_1) begin
					s_nxt.st = dxo_pkg::S_DONE;
					unique case (s_r.kind)
						dxo_pkg::K_A_RN: s_nxt.acc = rd8(addr_rn);
						dxo_pkg::K_RN_A: begin
							ram_we = 1'b1; ram_wa = addr_rn; ram_wd = s_r.acc;
						end
						dxo_pkg::K_A_DIR: s_nxt.acc = rd8(s_r.b1);
						dxo_pkg::K_A_IND: s_nxt.acc = rd8(ptr);
						dxo_pkg::K_A_IMM: s_nxt.acc = s_r.b1;
						dxo_pkg::K_RN_DIR: begin
							ram_we = 1'b1; ram_wa = addr_rn; ram_wd = rd8(s_r.b1);
						end
						dxo_pkg::K_RN_IMM: begin
							ram_we = 1'b1; ram_wa = addr_rn; ram_wd = s_r.b1;
						end
						dxo_pkg::K_DIR_A: begin
							ram_we = 1'b1; ram_wa = s_r.b1; ram_wd = s_r.acc;
						end
						dxo_pkg::K_DIR_RN: begin
							ram_we = 1'b1; ram_wa = s_r.b1; ram_wd = rd8(addr_rn);
						end
						dxo_pkg::K_DIR_IND: begin
							ram_we = 1'b1; ram_wa = s_r.b1; ram_wd = rd8(ptr);
						end
						dxo_pkg::K_DIR_DIR: begin
							// Source byte comes first in the encoding
							ram_we = 1'b1; ram_wa = s_r.b2; ram_wd = rd8(s_r.b1);
						end
						dxo_pkg::K_DIR_IMM: begin
							ram_we = 1'b1; ram_wa = s_r.b1; ram_wd = s_r.b2;
						end
						dxo_pkg::K_IND_A: begin
							ram_we = 1'b1; ram_wa = ptr; ram_wd = s_r.acc;
						end
						dxo_pkg::K_IND_DIR: begin
							ram_we = 1'b1; ram_wa = ptr; ram_wd = rd8(s_r.b1);
						end
						dxo_pkg::K_IND_IMM: begin
							ram_we = 1'b1; ram_wa = ptr; ram_wd = s_r.b1;
						end
						dxo_pkg::K_DP_LOAD: s_nxt.dp = {s_r.b1, s_r.b2};
						dxo_pkg::K_CODE_DP, dxo_pkg::K_CODE_PC: s_nxt.acc = code_rdata;
						dxo_pkg::K_XRD_IND, dxo_pkg::K_XRD_DP: s_nxt.acc = xdata_rdata;
						dxo_pkg::K_XWR_IND, dxo_pkg::K_XWR_DP: ;
						dxo_pkg::K_PUSH: begin
							s_nxt.sp = s_r.sp + 8'h01;
							ram_we = 1'b1; ram_wa = s_r.sp + 8'h01; ram_wd = rd8(s_r.b1);
						end
						dxo_pkg::K_POP: begin
							ram_we = 1'b1; ram_wa = s_r.b1; ram_wd = rd8(s_r.sp);
							s_nxt.sp = s_r.sp - 8'h01;
						end
						dxo_pkg::K_SWAP_RN: begin
							s_nxt.acc = rd8(addr_rn);
							ram_we = 1'b1; ram_wa = addr_rn; ram_wd = s_r.acc;
						end
						dxo_pkg::K_SWAP_DIR: begin
							s_nxt.acc = rd8(s_r.b1);
							ram_we = 1'b1; ram_wa = s_r.b1; ram_wd = s_r.acc;
						end
						dxo_pkg::K_SWAP_IND: begin
							s_nxt.acc = rd8(ptr);
							ram_we = 1'b1; ram_wa = ptr; ram_wd = s_r.acc;
						end
						dxo_pkg::K_NIB_SWAP: begin
							tmp = rd8(ptr);
							s_nxt.acc = (s_r.acc & ~dxo_pkg::LOW_NIBBLE) | (tmp & dxo_pkg::LOW_NIBBLE);
							ram_we = 1'b1; ram_wa = ptr;
							ram_wd = (tmp & ~dxo_pkg::LOW_NIBBLE) | (s_r.acc & dxo_pkg::LOW_NIBBLE);
						end
						default: ;
					endcase
					// Writes landing on the bank-select byte steer later register forms
					if (ram_we && ram_wa == dxo_pkg::SFR_BASE + dxo_pkg::BIT_RAM_BASE) begin
						s_nxt.psw_bank = ram_wd;
					end
				end
			end
			dxo_pkg::S_DONE: begin
				// Done pulses for one cycle, then the next instruction may be taken
				s_nxt.done = 1'b1;
				s_nxt.st = dxo_pkg::S_FETCH;
			end
			dxo_pkg::S_FETCH: begin
				s_nxt.illegal = 1'b0;
				s_nxt.ready = 1'b1;
				s_nxt.st = dxo_pkg::S_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register; clock enable freezes everything
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= dxo_pkg::S_IDLE;
			s_r.kind <= dxo_pkg::K_NONE;
			s_r.sp <= dxo_pkg::SP_RESET;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// Internal RAM array: no reset, contents are undefined at power-up
	always_ff @(posedge sys_clk) begin
		if (clk_en && ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

	// Outputs straight from the state flops
	assign instr_ready = s_r.ready;
	assign instr_done = s_r.done;
	assign instr_len = s_r.len;
	assign instr_illegal = s_r.illegal;
	assign xdata_req = s_r.xreq;
	assign code_req = s_r.creq;
	assign acc_out = s_r.acc;
	assign dp_out = s_r.dp;
	assign sp_out = s_r.sp;
endmodule

// *** bench/dxo_mem_model.sv ***
// Partner model: external data memory and code memory answering while a read request stands
`timescale 1ns/10ps
module dxo_mem_model (
	// Clock
	input wire logic sys_clk,
	// Requests from the core
	input wire dxo_pkg::dxo_mreq_t xdata_req,
	input wire dxo_pkg::dxo_mreq_t code_req,
	// Answers
	output logic [7:0] xdata_rdata,
	output logic [7:0] code_rdata
);
	logic [7:0] xm [0:65535];
	logic [7:0] code_byte;
	// ==========================================================
	// Answer within the cycle the request stands: the core captures on the edge that ends it
	// Without a read the inverse is shown, so a mistimed capture never matches
	assign xdata_rdata = xdata_req.rd ? xm[xdata_req.addr] : ~xm[xdata_req.addr];
	// Code space is read-only: content is a fixed address pattern
	assign code_byte = code_req.addr[7:0] ^ code_req.addr[15:8] ^ 8'h5A;
	assign code_rdata = code_req.rd ? code_byte : ~code_byte;
	// Writes land on the edge that sees the strobe
	always @(posedge sys_clk) begin
		if (xdata_req.wr) xm[xdata_req.addr] <= xdata_req.wdata;
	end
endmodule

// *** bench/dxo_core_monitor.sv ***
// Checker: timing and memory request relations at the core's ports
`timescale 1ns/10ps
module dxo_core_monitor #(
	parameter int RAM_WORDS = 256
) (
	// Clock, reset, inputs
	input wire logic sys_clk, rst, clk_en, instr_valid,
	input wire logic [7:0] instr_op, instr_b1, instr_b2,
	input wire logic [15:0] instr_pc,
	input wire logic [7:0] xdata_rdata, code_rdata, ind_page,
	// Outputs
	input wire logic instr_ready, instr_done, instr_illegal,
	input wire logic [1:0] instr_len,
	input wire dxo_pkg::dxo_mreq_t xdata_req, code_req,
	input wire logic [7:0] acc_out, sp_out,
	input wire logic [15:0] dp_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Instruction taken on this edge
	wire take = instr_valid && instr_ready && clk_en;
	code_ro_a: assert property (!code_req.wr) else $error("code write seen");
	xdir_excl_a: assert property (!(xdata_req.rd && xdata_req.wr)) else $error("xdata rd and wr");
	done_pulse_a: assert property (instr_done |=> !instr_done) else $error("done too long");
	ready_ret_a: assert property (instr_done |=> instr_ready) else $error("ready late");
	busy_low_a: assert property (take |=> !instr_ready [*2] ##1 (!instr_ready || $past(instr_illegal)))
		else $error("ready while busy");
	imm_acc_time_a: assert property (take && instr_op == dxo_pkg::OP_A_FROM_IMM |=>
		!instr_done [*3] ##1 instr_done) else $error("imm load timing");
	rn_acc_time_a: assert property (take && (instr_op & dxo_pkg::MASK_RN) == dxo_pkg::OP_A_FROM_RN |=>
		!instr_done [*2] ##1 instr_done) else $error("bank load timing");
	code_dp_time_a: assert property (take && instr_op == dxo_pkg::OP_CODE_DP |=>
		!instr_done [*6] ##1 instr_done) else $error("code read timing");
	dp_load_a: assert property (take && instr_op == dxo_pkg::OP_DP_LOAD |-> ##5 (instr_done &&
		instr_len == dxo_pkg::LEN_3 && dp_out == {$past(instr_b1, 5), $past(instr_b2, 5)})) else $error("dp load");
	push_sp_a: assert property (take && instr_op == dxo_pkg::OP_PUSH |-> ##5 (instr_done &&
		sp_out == 8'($past(sp_out, 5) + 8'h01))) else $error("push sp");
	xrd_addr_a: assert property (take && instr_op == dxo_pkg::OP_XRD_DP |->
		##[1:3] (xdata_req.rd && xdata_req.addr == dp_out)) else $error("xdata read addr");
	xwr_page_a: assert property (take && instr_op == dxo_pkg::OP_XWR_IND |-> ##[1:6] (xdata_req.wr &&
		xdata_req.addr[15:8] == ind_page && xdata_req.wdata == acc_out)) else $error("xdata write");
	// Main scenarios reached
	push_c: cover property (take && instr_op == dxo_pkg::OP_PUSH);
	xwr_c: cover property (xdata_req.wr);
	code_c: cover property (code_req.rd);
endmodule
bind dxo_core dxo_core_monitor #(.RAM_WORDS(RAM_WORDS)) u_mon (.*);

// *** bench/testbench.sv ***
// Testbench: transfer timing table plus data scenarios for the transfer executor
`timescale 1ns/10ps
module testbench;
	logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, instr_valid = 1'b0;
	logic [7:0] instr_op = 8'h00, instr_b1 = 8'h00, instr_b2 = 8'h00, ind_page = 8'h12;
	logic [15:0] instr_pc = 16'h0200;
	logic [7:0] xdata_rdata, code_rdata, acc_out, sp_out;
	logic instr_ready, instr_done, instr_illegal;
	logic [1:0] instr_len;
	logic [15:0] dp_out;
	dxo_pkg::dxo_mreq_t xdata_req, code_req;
	int bad_count = 0, n_tests = 0, cyc = 0, n;
	// Timing table: opcode, length, cycles; order keeps pointers inside RAM
	logic [7:0] ops [28] = '{8'h75, 8'h78, 8'hE8, 8'hE5, 8'hE6, 8'h74, 8'hF8, 8'hA8, 8'hF5, 8'h88, 8'h85, 8'h86,
		8'h76, 8'hF6, 8'hA6, 8'h90, 8'hC0, 8'hD0, 8'hC8, 8'hC5, 8'hC6, 8'hD6, 8'hF2, 8'hE2, 8'hF0, 8'hE0, 8'h93, 8'h83};
	logic [1:0] lens [28] = '{3, 2, 1, 2, 1, 2, 1, 2, 2, 2, 3, 2, 2, 1, 2, 3, 2, 2, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1};
	logic [2:0] cycs [28] = '{3, 2, 1, 2, 2, 2, 1, 3, 2, 2, 3, 3, 2, 2, 3, 3, 3, 2, 2, 3, 3, 3, 5, 4, 4, 3, 5, 4};
	dxo_core u_dut (.*);
	dxo_mem_model u_mem (.*);
	// ==========================================================
	// Clock and hang guard
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			results();
		end
	end
	task results();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One instruction; n counts edges from take to the done pulse
	task ex(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
		n = 0;
		while (instr_ready !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			#1 n++;
		end
		{instr_op, instr_b1, instr_b2} = {op, b1, b2};
		instr_valid = 1'b1;
		@(posedge sys_clk);
		#1 instr_valid = 1'b0;
		n = 0;
		while (instr_done !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			#1 n++;
		end
	endtask
	// ==========================================================
	// Scenarios
	task t_table();
		for (int i = 0; i < 28; i++) begin
			ex(ops[i], 8'h30, 8'h31);
			chk(16'(n), 16'(cycs[i]) + 16'h0001);
			chk(16'(instr_len), 16'(lens[i]));
		end
	endtask
	task t_code();
		ex(8'h74, 8'h03, 8'h00);
		ex(8'h90, 8'h01, 8'h00);
		ex(8'h93, 8'h00, 8'h00);
		chk(16'(acc_out), 16'h0058);
		ex(8'h74, 8'h05, 8'h00);
		ex(8'h83, 8'h00, 8'h00);
		chk(16'(acc_out), 16'h005D);
	endtask
	task t_xdata();
		ex(8'h74, 8'h5A, 8'h00);
		ex(8'h90, 8'h12, 8'h34);
		chk(dp_out, 16'h1234);
		ex(8'hF0, 8'h00, 8'h00);
		ex(8'h74, 8'h00, 8'h00);
		ex(8'hE0, 8'h00, 8'h00);
		chk(16'(acc_out), 16'h005A);
		ex(8'h78, 8'h34, 8'h00);
		ex(8'h74, 8'h00, 8'h00);
		ex(8'hE2, 8'h00, 8'h00);
		chk(16'(acc_out), 16'h005A);
	endtask
	task t_stack();
		ex(8'h75, 8'h40, 8'h77);
		ex(8'hC0, 8'h40, 8'h00);
		chk(16'(sp_out), 16'h0008);
		ex(8'hD0, 8'h50, 8'h00);
		chk(16'(sp_out), 16'h0007);
		ex(8'hE5, 8'h50, 8'h00);
		chk(16'(acc_out), 16'h0077);
	endtask
	task t_nibble();
		ex(8'h75, 8'h30, 8'hAB);
		ex(8'h78, 8'h30, 8'h00);
		ex(8'h74, 8'h5C, 8'h00);
		ex(8'hD6, 8'h00, 8'h00);
		chk(16'(acc_out), 16'h005B);
		ex(8'hE5, 8'h30, 8'h00);
		chk(16'(acc_out), 16'h00AC);
	endtask
	task t_illegal();
		ex(8'hA5, 8'h00, 8'h00);
		chk(16'(instr_illegal), 16'h0001);
		ex(8'h74, 8'h11, 8'h00);
		chk(16'(instr_illegal), 16'h0000);
	endtask
	// Enable low: a request is not taken and nothing moves until enable returns
	task t_freeze();
		ex(8'h74, 8'h21, 8'h00);
		@(posedge sys_clk);
		#1 clk_en = 1'b0;
		ex(8'h74, 8'h22, 8'h00);
		chk(16'({n[7:0], acc_out}), 16'h3221);
		clk_en = 1'b1;
		ex(8'h74, 8'h22, 8'h00);
		chk(16'(acc_out), 16'h0022);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk(16'(sp_out), 16'h0007);
		t_table();
		t_code();
		t_xdata();
		t_stack();
		t_nibble();
		t_illegal();
		t_freeze();
		results();
	end
endmodule
